// [usb_far_model.sv]
`timescale 1ns/100ps
`default_nettype none
module usb_far_model (
	input wire logic CLK_SYS,
	output logic SE0_LIVE,
	output logic LINE_DRIVE,
	output logic SETUP_TOKEN,
	output logic FRAME_LOAD,
	output logic [10:0] FRAME_NUMBER,
	output logic [7:0] ERROR_EVENT,
	output logic EOF_ERROR
);
	logic se0, drv;
	logic [21:0] ev;
	assign {SETUP_TOKEN, FRAME_LOAD, FRAME_NUMBER, ERROR_EVENT, EOF_ERROR} = ev;
	assign SE0_LIVE = se0;
	assign LINE_DRIVE = drv;
	initial begin
		se0 = 1'b0;
		drv = 1'b0;
		ev = '0;
	end
	task lines(input logic s, input logic d);
		@(posedge CLK_SYS);
		se0 <= s;
		drv <= d;
	endtask
	// one-cycle events; frame value is not held past its strobe
	task pulse(input logic [21:0] p);
		@(posedge CLK_SYS);
		ev <= p;
		@(posedge CLK_SYS);
		ev <= {2'b00, ~p[19:9], 9'h000};
	endtask
endmodule
`default_nettype wire

// [usb_otg_control_registers_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module usb_otg_control_registers_bench;
	import usb_otg_ctrl_pkg::*;
	logic CLK_SYS, RESET_N, CLK_EN, CYC_I, STB_I, WE_I, ACK_O, ERROR_IRQ;
	logic [7:0] ADR_I, ERROR_EVENT, DESC_PAGE;
	logic [31:0] DAT_I, DAT_O, q;
	logic [3:0] SEL_I;
	logic SE0_LIVE, SETUP_TOKEN, FRAME_LOAD, EOF_ERROR, LINE_DRIVE;
	logic [10:0] FRAME_NUMBER;
	logic MODULE_ENABLE, DP_PULLUP, DP_PULLDOWN, DM_PULLDOWN, HOST_MODE;
	logic RESUME_DRIVE, PINGPONG_RESET, PACKET_HALT, EYE_TEST;
	logic TRANSCEIVER_OFF, OE_MONITOR;
	logic [1:0] PINGPONG_MODE;
	int n_errors, checked;
	usb_otg_ctrl_regs DUT (.*);
	usb_far_model far (.*);
	initial begin
		CLK_SYS = 1'b0;
		forever #25 CLK_SYS = ~CLK_SYS;
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// ====================
	// bus cycles; outputs are judged at the falling edge after
	task wb(input logic [7:0] a, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge CLK_SYS);
		CYC_I <= 1'b1;
		STB_I <= 1'b1;
		WE_I <= w;
		ADR_I <= a;
		DAT_I <= {24'h0, d};
		do begin
			@(posedge CLK_SYS);
			n++;
		end while (ACK_O !== 1'b1 && n < 9);
		if (n >= 9) chk("ack", 1, 0);
		q = DAT_O;
		CYC_I <= 1'b0;
		STB_I <= 1'b0;
		@(negedge CLK_SYS);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		wb(a, 1'b0, 8'h00);
		chk(nm, {24'h0, e}, q);
	endtask
	// ====================
	// scenarios
	task t_setup;
		rd(8'h40, 8'h00, "unmapped");
		far.pulse({2'b10, 20'h0});
		rd(OFS_CONTROL, 8'h20, "control");
		wb(OFS_CONTROL, 1'b1, 8'h00);
		chk("halt", 0, PACKET_HALT);
		// a token while the clock enable is low must be lost
		@(posedge CLK_SYS);
		CLK_EN <= 1'b0;
		far.pulse({2'b10, 20'h0});
		CLK_EN <= 1'b1;
		@(negedge CLK_SYS);
		chk("freeze", 0, PACKET_HALT);
	endtask
	task t_control;
		far.lines(1'b1, 1'b0);
		wb(OFS_CONTROL, 1'b1, 8'hF7);
		rd(OFS_CONTROL, 8'h67, "control");
		chk("attach", 4'hF, {MODULE_ENABLE, DP_PULLUP, RESUME_DRIVE, PINGPONG_RESET});
		wb(OFS_CONTROL, 1'b1, 8'h08);
		chk("host", 5'h1C, {HOST_MODE, DP_PULLDOWN, DM_PULLDOWN, DP_PULLUP, PACKET_HALT});
	endtask
	task t_config;
		far.lines(1'b0, 1'b1);
		wb(OFS_CONFIG_ONE, 1'b1, 8'hFF);
		rd(OFS_CONFIG_ONE, 8'hD3, "config1");
		chk("eye", 4'hE, {EYE_TEST, PINGPONG_MODE, OE_MONITOR});
		wb(OFS_CONFIG_TWO, 1'b1, 8'h01);
		chk("oemon", 2'h3, {TRANSCEIVER_OFF, OE_MONITOR});
		for (int i = 0; i < 2; i++) begin
			wb(OFS_CONFIG_ONE, 1'b1, i[7:0]);
			chk("pingpong", {1'b0, i[1:0]}, {EYE_TEST, PINGPONG_MODE});
		end
	endtask
	task t_data;
		wb(OFS_DESC_PAGE, 1'b1, 8'hFF);
		rd(OFS_DESC_PAGE, 8'hFE, "page");
		chk("pageport", 8'hFE, DESC_PAGE);
		far.pulse({2'b01, 11'h5A3, 9'h0});
		rd(OFS_FRAME_LOW, 8'hA3, "framelow");
		rd(OFS_FRAME_HIGH, 8'h05, "framehigh");
	endtask
	// host mode still on: bit 1 comes from end-of-frame, bit 6 unused
	task t_errors;
		wb(OFS_ERR_ENABLE, 1'b1, 8'hFF);
		rd(OFS_ERR_ENABLE, 8'hBF, "errenable");
		far.pulse({13'h0, 8'h42, 1'b0});
		rd(OFS_ERR_STATUS, 8'h00, "errstatus");
		far.pulse({13'h0, 8'h80, 1'b1});
		rd(OFS_ERR_STATUS, 8'h82, "errstatus");
		chk("irq", 1, ERROR_IRQ);
		wb(OFS_ERR_ENABLE, 1'b1, 8'h3D);
		chk("irqmask", 0, ERROR_IRQ);
		wb(OFS_ERR_STATUS, 1'b1, 8'h82);
		wb(OFS_CONTROL, 1'b1, 8'h00);
		far.pulse({13'h0, 8'h02, 1'b0});
		rd(OFS_ERR_STATUS, 8'h02, "errstatus");
		wb(OFS_ERR_ENABLE, 1'b1, 8'h02);
		chk("irq", 1, ERROR_IRQ);
	endtask
	task stop_test;
		$display("checked %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		n_errors++;
		stop_test();
	end
	initial begin
		{RESET_N, CYC_I, STB_I, WE_I, ADR_I, DAT_I} = '0;
		CLK_EN = 1'b1;
		SEL_I = 4'h1;
		n_errors = 0;
		checked = 0;
		repeat (3) @(posedge CLK_SYS);
		RESET_N <= 1'b1;
		rd(OFS_ERR_ENABLE, 8'h00, "errenable");
		t_setup();
		t_control();
		t_config();
		t_data();
		t_errors();
		stop_test();
	end
endmodule
`default_nettype wire

// [usb_otg_ctrl_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module usb_otg_ctrl_checker (
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	input wire logic CLK_EN,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic ACK_O,
	input wire logic [31:0] DAT_O,
	input wire logic SETUP_TOKEN,
	input wire logic LINE_DRIVE,
	input wire logic MODULE_ENABLE,
	input wire logic DP_PULLUP,
	input wire logic DP_PULLDOWN,
	input wire logic DM_PULLDOWN,
	input wire logic HOST_MODE,
	input wire logic PACKET_HALT,
	input wire logic TRANSCEIVER_OFF,
	input wire logic OE_MONITOR,
	input wire logic [7:0] DESC_PAGE
);
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RESET_N);
	// ====================
	// bus handshake
	sequence s_take;
		CLK_EN && CYC_I && STB_I && !ACK_O;
	endsequence
	sequence s_ack;
		ACK_O ##1 !ACK_O;
	endsequence
	a_ack_timing: assert property (s_take |=> s_ack)
		else $error("ack not one cycle after request");
	a_upper_zero: assert property (ACK_O |-> DAT_O[31:8] == 24'h0)
		else $error("upper read byte not zero");
	// ====================
	// line control, descriptor page and packet halt
	a_host_pulls: assert property (
		DP_PULLDOWN == HOST_MODE && DM_PULLDOWN == HOST_MODE)
		else $error("pull-downs do not follow host enable");
	a_attach_pull: assert property (
		DP_PULLUP == (MODULE_ENABLE && !HOST_MODE))
		else $error("d+ pull-up wrong");
	a_oe_gate: assert property (
		OE_MONITOR |-> TRANSCEIVER_OFF && LINE_DRIVE)
		else $error("oe monitor without transceiver disabled");
	a_page_even: assert property (DESC_PAGE[0] == 1'b0)
		else $error("descriptor page odd");
	a_setup_halt: assert property (CLK_EN && SETUP_TOKEN |=> PACKET_HALT)
		else $error("setup token did not halt packets");
	a_halt_clear: assert property ($fell(PACKET_HALT) |-> $past(ACK_O))
		else $error("packet halt cleared without a bus write");
endmodule
bind usb_otg_ctrl_regs usb_otg_ctrl_checker chk_i (.*);
`default_nettype wire

// [usb_otg_ctrl_pkg.sv]
`default_nettype none
package usb_otg_ctrl_pkg;
	// ==========================================
	// bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	localparam logic [7:0] IMPL_BYTE_MASK = 8'hFF;
	// ==========================================
	// register byte addresses
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_CONFIG_ONE = 8'h04;
	localparam logic [7:0] OFS_CONFIG_TWO = 8'h08;
	localparam logic [7:0] OFS_ERR_ENABLE = 8'h0C;
	localparam logic [7:0] OFS_ERR_STATUS = 8'h10;
	localparam logic [7:0] OFS_DESC_PAGE = 8'h14;
	localparam logic [7:0] OFS_FRAME_LOW = 8'h18;
	localparam logic [7:0] OFS_FRAME_HIGH = 8'h1C;
	// ==========================================
	// control register fields
	localparam int CTL_MODULE_ENABLE = 0;
	localparam int CTL_PTR_RESET = 1;
	localparam int CTL_RESUME = 2;
	localparam int CTL_HOST_ENABLE = 3;
	localparam int CTL_PKT_DISABLE = 5;
	localparam int CTL_SE0 = 6;
	localparam logic [7:0] CTL_WRITE_MASK = 8'h2F;
	// ==========================================
	// configuration fields
	localparam int CFG1_PPB_LSB = 0;
	localparam int CFG1_STOP_IDLE = 4;
	localparam int CFG1_OE_MONITOR = 6;
	localparam int CFG1_EYE_TEST = 7;
	localparam logic [7:0] CFG1_WRITE_MASK = 8'hD3;
	localparam int CFG2_XCVR_DISABLE = 0;
	localparam logic [7:0] CFG2_WRITE_MASK = 8'h01;
	// ==========================================
	// error bits: bitstuff 7, dma 5, turnaround 4, size 3,
	// crc16 2, crc5 or eof 1, pid 0
	localparam int ERR_CRC5_EOF = 1;
	localparam logic [7:0] ERR_IMPL_MASK = 8'hBF;
	localparam logic [7:0] PAGE_WRITE_MASK = 8'hFE;
	// ==========================================
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [10:0] RST_FRAME = 11'h000;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} bus_state_t;
endpackage
`default_nettype wire

// [usb_otg_ctrl_regs.sv]
// Operation
// R1: registers use low byte; upper byte zero
// R2: 8-bit descriptor page, bit 0 zero
// R3: 11-bit frame count, low/high readable
// R4: bit 6 shows live single-ended zero
// R5: packet disable halts; setup token sets it
// R6: host enable adds pull-downs on D+/D-
// R7: resume bit drives resume signalling; code drives it only while module enable is also set
// R8: pointer reset returns buffers to even
// R9: module enable powers engine, D+ pull-up; code drops the D+ pull-up while host enable is set
// R10: config bit 7 selects eye-pattern test
// R11: output-enable monitor needs transceiver disabled
// R12: ping-pong field 00 off, 01 OUT0
// R13: one enable per error type, bit 6 zero
// R14: enable bit 1 crc5 device, eof host
// R15: some bits change meaning in host mode
// R16: enabled error flags ORed into interrupt
`timescale 1ns/100ps
`default_nettype none
module usb_otg_ctrl_regs
	import usb_otg_ctrl_pkg::*;
#(
	parameter int FRAME_BITS = 11
) (
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	input wire logic CLK_EN,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [usb_otg_ctrl_pkg::ADDR_W-1:0] ADR_I,
	input wire logic [usb_otg_ctrl_pkg::DATA_W-1:0] DAT_I,
	input wire logic [3:0] SEL_I,
	output logic [usb_otg_ctrl_pkg::DATA_W-1:0] DAT_O,
	output logic ACK_O,
	input wire logic SE0_LIVE,
	input wire logic SETUP_TOKEN,
	input wire logic FRAME_LOAD,
	input wire logic [FRAME_BITS-1:0] FRAME_NUMBER,
	input wire logic [7:0] ERROR_EVENT,
	input wire logic EOF_ERROR,
	input wire logic LINE_DRIVE,
	output logic MODULE_ENABLE,
	output logic DP_PULLUP,
	output logic DP_PULLDOWN,
	output logic DM_PULLDOWN,
	output logic HOST_MODE,
	output logic RESUME_DRIVE,
	output logic PINGPONG_RESET,
	output logic [1:0] PINGPONG_MODE,
	output logic PACKET_HALT,
	output logic EYE_TEST,
	output logic TRANSCEIVER_OFF,
	output logic OE_MONITOR,
	output logic [7:0] DESC_PAGE,
	output logic ERROR_IRQ
);
	import usb_otg_ctrl_pkg::*;

	// high register only carries bits 10:8, so other widths cannot fit
	if (FRAME_BITS != 11) begin : g_bad_frame_bits
		$error("frame counter width must be 11");
	end

	// ==========================================
	// state
	bus_state_t bus_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic [7:0] ctl_ff;
	logic [7:0] cfg1_ff;
	logic [7:0] cfg2_ff;
	logic [7:0] eie_ff;
	logic [7:0] err_ff;
	logic [7:0] page_ff;
	logic [FRAME_BITS-1:0] frame_ff;
	logic [7:0] wbyte;
	logic wr_lane;
	logic wr_ctl;
	logic wr_cfg1;
	logic wr_cfg2;
	logic wr_eie;
	logic wr_err;
	logic wr_page;
	logic [7:0] err_event;
	logic [7:0] nxt_rbyte;
	logic [7:0] ctl_view;

	// ==========================================
	// wishbone slave: one wait state, then ack
	// write commits on the ack edge, when the master samples it
	assign wbyte = DAT_I[7:0];
	assign wr_lane = CYC_I && STB_I && WE_I && SEL_I[0] &&
		(bus_ff == BUS_ACK);
	assign wr_ctl = wr_lane && (ADR_I == OFS_CONTROL);
	assign wr_cfg1 = wr_lane && (ADR_I == OFS_CONFIG_ONE);
	assign wr_cfg2 = wr_lane && (ADR_I == OFS_CONFIG_TWO);
	assign wr_eie = wr_lane && (ADR_I == OFS_ERR_ENABLE);
	assign wr_err = wr_lane && (ADR_I == OFS_ERR_STATUS);
	assign wr_page = wr_lane && (ADR_I == OFS_DESC_PAGE);
	assign ACK_O = (bus_ff == BUS_ACK);
	assign DAT_O = rdata_ff;

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			bus_ff <= BUS_IDLE;
		end else if (CLK_EN) begin
			case (bus_ff)
				BUS_IDLE: begin
					if (CYC_I && STB_I)
						bus_ff <= BUS_ACK;
				end
				BUS_ACK: begin
					bus_ff <= BUS_IDLE;
				end
				default: begin
					bus_ff <= BUS_IDLE;
				end
			endcase
		end
	end

	// live flag is not stored, so a read sees the line as sampled in the request cycle, one cycle before ack
	always_comb begin
		ctl_view = ctl_ff & CTL_WRITE_MASK;
		ctl_view[CTL_SE0] = SE0_LIVE; // [R4]
	end

	always_comb begin
		case (ADR_I)
			OFS_CONTROL: nxt_rbyte = ctl_view;
			OFS_CONFIG_ONE: nxt_rbyte = cfg1_ff;
			OFS_CONFIG_TWO: nxt_rbyte = cfg2_ff;
			OFS_ERR_ENABLE: nxt_rbyte = eie_ff & ERR_IMPL_MASK; // [R13]
			OFS_ERR_STATUS: nxt_rbyte = err_ff;
			OFS_DESC_PAGE: nxt_rbyte = page_ff;
			OFS_FRAME_LOW: nxt_rbyte = frame_ff[7:0]; // [R3]
			OFS_FRAME_HIGH: nxt_rbyte = {5'h00, frame_ff[10:8]}; // [R3]
			default: nxt_rbyte = RST_BYTE;
		endcase
	end

	// upper bytes carry nothing and read as zero
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			rdata_ff <= '0;
		end else if (CLK_EN) begin
			if (CYC_I && STB_I && !WE_I && bus_ff == BUS_IDLE)
				rdata_ff <= {24'h000000, nxt_rbyte}; // [R1]
			else if (bus_ff == BUS_ACK)
				rdata_ff <= '0;
		end
	end

	// ==========================================
	// control register
	// a setup token in the same cycle as a clearing write wins
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			ctl_ff <= RST_BYTE;
		end else if (CLK_EN) begin
			if (wr_ctl)
				ctl_ff <= wbyte & CTL_WRITE_MASK; // [R1]
			if (SETUP_TOKEN)
				ctl_ff[CTL_PKT_DISABLE] <= 1'b1; // [R5]
		end
	end

	// ==========================================
	// configuration registers
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			cfg1_ff <= RST_BYTE;
		end else if (CLK_EN && wr_cfg1) begin
			cfg1_ff <= wbyte & CFG1_WRITE_MASK;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			cfg2_ff <= RST_BYTE;
		end else if (CLK_EN && wr_cfg2) begin
			cfg2_ff <= wbyte & CFG2_WRITE_MASK;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			page_ff <= RST_BYTE;
		end else if (CLK_EN && wr_page) begin
			page_ff <= wbyte & PAGE_WRITE_MASK; // [R2]
		end
	end

	// ==========================================
	// frame counter, loaded by the engine at each frame start
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			frame_ff <= RST_FRAME;
		end else if (CLK_EN && FRAME_LOAD) begin
			frame_ff <= FRAME_NUMBER; // [R3]
		end
	end

	// ==========================================
	// error enables, sticky status and interrupt
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			eie_ff <= RST_BYTE;
		end else if (CLK_EN && wr_eie) begin
			eie_ff <= wbyte & ERR_IMPL_MASK; // [R13]
		end
	end

	// bit 1 source follows the mode so one enable serves both roles
	always_comb begin
		err_event = ERROR_EVENT & ERR_IMPL_MASK;
		err_event[ERR_CRC5_EOF] = ctl_ff[CTL_HOST_ENABLE] ?
			EOF_ERROR : ERROR_EVENT[ERR_CRC5_EOF]; // [R14] [R15]
	end

	// write one to clear; a new event in that cycle stays set
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			err_ff <= RST_BYTE;
		end else if (CLK_EN) begin
			if (wr_err)
				err_ff <= (err_ff & ~wbyte) | err_event;
			else
				err_ff <= err_ff | err_event;
		end
	end

	assign ERROR_IRQ = |(err_ff & eie_ff & ERR_IMPL_MASK); // [R16]

	// ==========================================
	// line and engine controls
	assign MODULE_ENABLE = ctl_ff[CTL_MODULE_ENABLE]; // [R9]
	assign DP_PULLUP = ctl_ff[CTL_MODULE_ENABLE] &&
		!ctl_ff[CTL_HOST_ENABLE]; // [R9]
	assign HOST_MODE = ctl_ff[CTL_HOST_ENABLE]; // [R6]
	assign DP_PULLDOWN = ctl_ff[CTL_HOST_ENABLE]; // [R6]
	assign DM_PULLDOWN = ctl_ff[CTL_HOST_ENABLE]; // [R6]
	// resume stops as soon as software clears the bit
	assign RESUME_DRIVE = ctl_ff[CTL_RESUME] &&
		ctl_ff[CTL_MODULE_ENABLE]; // [R7]
	assign PINGPONG_RESET = ctl_ff[CTL_PTR_RESET]; // [R8]
	assign PACKET_HALT = ctl_ff[CTL_PKT_DISABLE]; // [R5]
	assign PINGPONG_MODE = cfg1_ff[CFG1_PPB_LSB+1:CFG1_PPB_LSB]; // [R12]
	assign EYE_TEST = cfg1_ff[CFG1_EYE_TEST]; // [R10]
	assign TRANSCEIVER_OFF = cfg2_ff[CFG2_XCVR_DISABLE];
	// monitor is meaningless with the on-chip transceiver in use
	assign OE_MONITOR = cfg1_ff[CFG1_OE_MONITOR] &&
		cfg2_ff[CFG2_XCVR_DISABLE] && LINE_DRIVE; // [R11]
	assign DESC_PAGE = page_ff; // [R2]
endmodule
`default_nettype wire
